// >>> hw/oer_pkg.sv
// Shared constants for the octal edge register with tri-state outputs
package oer_pkg;
  // Number of storage channels
  localparam int OER_WIDTH = 8;
  // Output drive control level that enables the drivers (active low)
  localparam logic OER_DRIVE_ON = 1'h0;
  // Driver enable states
  localparam logic OER_OE_DRIVE = 1'h1;
  localparam logic OER_OE_RELEASE = 1'h0;
  // Capture clock sampler value at reset: high, so no false rise at release
  localparam logic OER_CLK_PREV_RST = 1'h1;
endpackage : oer_pkg

// >>> hw/oer_bus_hold.sv
// Bus-hold keeper for the capture inputs
`timescale 1ns/1ps
module oer_bus_hold #(
  parameter int WIDTH = oer_pkg::OER_WIDTH
) (
  input wire logic mclk,
  input wire logic [WIDTH-1:0] pin_level,
  input wire logic [WIDTH-1:0] pin_driven,
  output logic [WIDTH-1:0] kept_level
);

  // Refuse a channel count the logic cannot serve, at elaboration
  if (WIDTH < 1)
  begin : g_bad_width
    $error("oer_bus_hold: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] keep_r;
  logic [WIDTH-1:0] keep_nxt;

  // Driven bits pass straight through; floating bits show the kept level
  assign keep_nxt = (pin_level & pin_driven) | (keep_r & ~pin_driven);
  assign kept_level = keep_nxt;

  // Keeper has no reset: like the real hold cell it starts unknown
  always_ff @(posedge mclk)
  begin
    keep_r <= keep_nxt;
  end

endmodule : oer_bus_hold

// >>> hw/oer_octal_reg.sv
// Octal edge-triggered register with shared tri-state output control
//
// What this block does
// - Eight single-bit storage channels share one capture clock and one drive control.
// - Each rising capture clock edge outside reset loads every channel from its input.
// - Channels change only on a rising capture edge, otherwise hold.
// - Drive control low drives all outputs; high releases all to high impedance.
// - Drive control never touches storage; capture continues while released.
// - Outputs stay released during power transitions, modelled by reset.
// - Undriven capture inputs keep their last valid level.
`timescale 1ns/1ps
module oer_octal_reg #(
  parameter int WIDTH = oer_pkg::OER_WIDTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cap_clk,
  input wire logic drive_off_n,
  input wire logic [WIDTH-1:0] cap_d,
  input wire logic [WIDTH-1:0] cap_d_driven,
  output logic [WIDTH-1:0] held_level,
  output logic [WIDTH-1:0] held_level_oe
);

  // Elaboration guard: storage and driver fan-out serve the octal count only
  if (WIDTH != oer_pkg::OER_WIDTH)
  begin : g_bad_width
    $error("oer_octal_reg: WIDTH must equal the channel count");
  end

  // Rise of a sampled level: high now, low at the previous mclk edge
  function automatic logic oer_rise_of(
    input logic level_now,
    input logic level_before
  );
    return level_now & ~level_before;
  endfunction : oer_rise_of

  // Load a fresh bit or keep the stored one
  function automatic logic oer_pick(
    input logic load,
    input logic fresh,
    input logic kept
  );
    return load ? fresh : kept;
  endfunction : oer_pick

  // Spread one driver enable level over every channel
  function automatic logic [WIDTH-1:0] oer_fan(
    input logic level
  );
    return {WIDTH{level}};
  endfunction : oer_fan

  // Every driver released; a constant, so the reset branch stays pure
  localparam logic [WIDTH-1:0] OE_ALL_OFF = {WIDTH{oer_pkg::OER_OE_RELEASE}};

  logic cap_clk_prev_r;
  logic [WIDTH-1:0] oe_r;
  logic [WIDTH-1:0] oe_nxt;
  logic [WIDTH-1:0] kept_d;
  wire [WIDTH-1:0] store_q;
  wire cap_rise;
  wire drive_req;

  // Floating inputs are held before they reach storage
  oer_bus_hold #(
    .WIDTH(WIDTH)
  ) u_hold (
    .mclk(mclk),
    .pin_level(cap_d),
    .pin_driven(cap_d_driven),
    .kept_level(kept_d)
  );

  // Capture clock is a synchronous input; a rise is low at one edge, high at the next
  assign cap_rise = oer_rise_of(cap_clk, cap_clk_prev_r);

  // Edge sampler; reset high so a clock already high at release is no edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_clk_prev_r <= oer_pkg::OER_CLK_PREV_RST;
    end
    else
    begin
      cap_clk_prev_r <= cap_clk;
    end
  end

  // One storage flop per channel; channels share only the capture rise
  for (genvar ch = 0; ch < WIDTH; ch = ch + 1)
  begin : g_chan
    logic chan_r;
    wire chan_nxt;

    // Keeper output feeds storage, so a floating pin loads the level last driven on it
    assign chan_nxt = oer_pick(cap_rise, kept_d[ch], chan_r);

    // No reset and no drive control here: contents survive release and reset
    always_ff @(posedge mclk)
    begin
      chan_r <= chan_nxt;
    end

    assign store_q[ch] = chan_r;
  end

  // Drive request looks only at the control, never at stored data
  assign drive_req = (drive_off_n == oer_pkg::OER_DRIVE_ON);
  assign oe_nxt = oer_fan(drive_req);

  // Driver enables: released throughout reset, which stands for a power ramp
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_r <= OE_ALL_OFF;
    end
    else
    begin
      oe_r <= oe_nxt;
    end
  end

  // Pins come straight from flops; the enable decides whether the level is seen
  assign held_level = store_q;
  assign held_level_oe = oe_r;

endmodule : oer_octal_reg

// >>> verif/oer_octal_reg_monitor.sv
// Port checker for the octal edge register
`timescale 1ns/1ps
module oer_octal_reg_mon #(
  parameter int WIDTH = oer_pkg::OER_WIDTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cap_clk,
  input wire logic drive_off_n,
  input wire logic [WIDTH-1:0] cap_d,
  input wire logic [WIDTH-1:0] cap_d_driven,
  input wire logic [WIDTH-1:0] held_level,
  input wire logic [WIDTH-1:0] held_level_oe
);
  logic [WIDTH-1:0] keep_r;
  logic ld_r = 1'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Keeper image and a loaded flag, so an unknown store is never judged
  always_ff @(posedge mclk)
    keep_r <= (cap_d & cap_d_driven) | (keep_r & ~cap_d_driven);
  always_ff @(posedge mclk) ld_r <= ld_r | (rst_n & cap_clk);
  sequence rise;
    $past(rst_n) && cap_clk && !$past(cap_clk);
  endsequence
  chk_cap_load: assert property (rise |=>
    ((held_level ^ $past(cap_d)) & $past(cap_d_driven)) == 0)
    else $error("load");
  chk_float_keep: assert property (rise |=>
    ((held_level ^ $past(keep_r)) & ~$past(cap_d_driven)) == 0)
    else $error("keep");
  chk_hold_still: assert property (ld_r && !(cap_clk && !$past(cap_clk)) |=> $stable(held_level))
    else $error("hold");
  chk_oe_follow: assert property ($past(rst_n) |->
    held_level_oe == {WIDTH{~$past(drive_off_n)}})
    else $error("oe");
  chk_oe_power: assert property (disable iff (1'h0) !rst_n |->
    held_level_oe == {WIDTH{1'h0}})
    else $error("power");
  chk_store_kept: assert property (disable iff (1'h0) ld_r && !rst_n |=> $stable(held_level))
    else $error("store");
endmodule : oer_octal_reg_mon
bind oer_octal_reg oer_octal_reg_mon #(.WIDTH(WIDTH)) mon (.mclk(mclk), .rst_n(rst_n),
  .cap_clk(cap_clk),
  .drive_off_n(drive_off_n), .cap_d(cap_d), .cap_d_driven(cap_d_driven),
  .held_level(held_level), .held_level_oe(held_level_oe));

// >>> verif/oer_bus_peer.sv
// Shared bus line model beside the register outputs
`timescale 1ns/1ps
module oer_bus_peer (
  input wire logic [7:0] held_level,
  input wire logic [7:0] held_level_oe,
  output logic [7:0] bus_line
);
  // Released lines show the inverse, so a stale value never passes
  assign bus_line = held_level ^ ~held_level_oe;
endmodule : oer_bus_peer

// >>> verif/test_octal_edge_register_tristate.sv
// Self-checking bench for the octal edge register
`timescale 1ns/1ps
`define CHK(n,e,a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module test_octal_edge_register_tristate;
  // Reset starts high and falls at time zero, so the async reset really fires
  logic mclk = 1'h0, rst_n = 1'h1, cap_clk = 1'h0, drive_off_n = 1'h1;
  logic [7:0] cap_d = 8'h00, cap_d_driven = 8'hFF, held_level, held_level_oe, bus_line;
  int n_errors = 0, comparisons = 0, cyc = 0;
  oer_octal_reg dut (.mclk(mclk), .rst_n(rst_n), .cap_clk(cap_clk), .drive_off_n(drive_off_n),
    .cap_d(cap_d), .cap_d_driven(cap_d_driven), .held_level(held_level),
    .held_level_oe(held_level_oe));
  oer_bus_peer peer (.held_level(held_level), .held_level_oe(held_level_oe), .bus_line(bus_line));
  initial forever #5 mclk = ~mclk;
  // Hang guard: the tests need well under 200 cycles
  always @(posedge mclk) if (++cyc > 400) begin n_errors++; conclude(); end
  task automatic cap(input logic [7:0] d, drv, exp);
    @(posedge mclk) begin cap_d <= d; cap_d_driven <= drv; cap_clk <= 1'h0; end
    @(posedge mclk) cap_clk <= 1'h1;
    repeat (2) @(posedge mclk);
    #1 `CHK("held", exp, held_level)
  endtask : cap
  task automatic t_drive;
    @(posedge mclk) drive_off_n <= 1'h0;
    cap(8'hA5, 8'hFF, 8'hA5);
    cap(8'h5A, 8'hFF, 8'h5A);
    `CHK("bus", 8'h5A, bus_line)
    // New data while the clock rests high, then falls: neither may load
    @(posedge mclk) cap_d <= 8'hFF;
    repeat (3) @(posedge mclk);
    @(posedge mclk) cap_clk <= 1'h0;
    repeat (3) @(posedge mclk);
    #1 `CHK("hold", 8'h5A, held_level)
    $display("t_drive done");
  endtask : t_drive
  task automatic t_release;
    @(posedge mclk) drive_off_n <= 1'h1;
    cap(8'h3C, 8'hFF, 8'h3C);
    `CHK("oe", 8'h00, held_level_oe)
    cap(8'hFF, 8'h00, 8'h3C);
    @(posedge mclk) begin drive_off_n <= 1'h0; rst_n <= 1'h0; end
    repeat (2) @(posedge mclk);
    #1 `CHK("rst_oe", 8'h00, held_level_oe)
    `CHK("rst_held", 8'h3C, held_level)
    @(posedge mclk) rst_n <= 1'h1;
    repeat (2) @(posedge mclk);
    #1 `CHK("oe_on", 8'hFF, held_level_oe)
    $display("t_release done");
  endtask : t_release
  task automatic conclude;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    rst_n <= 1'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (2) @(posedge mclk);
    t_drive();
    t_release();
    conclude();
  end
endmodule : test_octal_edge_register_tristate
